// file: edge_divider.sv
// Programmable divider of a one-cycle tick stream
`timescale 1ns/1ps
`default_nettype none

module edge_divider #(
  parameter int W = 10
) (
  // Clock and control
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Tick stream
  input wire logic tick_i,
  input wire logic [W-1:0] ratio_i,
  output logic tick_o
);

  initial begin
    if (W < 1) $error("edge_divider: W must be at least 1");
  end

  logic [W-1:0] count;

  // ----------------------------------------------------------------
  // Counter: one output tick per ratio input ticks
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count <= '0;
      tick_o <= 1'b0;
    end else if (ce_i) begin
      tick_o <= 1'b0;
      if (tick_i) begin
        if (count + W'(1) >= ratio_i) begin
          count <= '0;
          tick_o <= 1'b1;
        end else begin
          count <= count + W'(1);
        end
      end
    end
  end

endmodule : edge_divider

`default_nettype wire

// file: loop_return_model.sv
// Graphics controller model that divides the returned clock and sends it back
`timescale 1ns/1ps
`default_nettype none
module loop_return_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Clock pins
  input wire logic rclk_i,
  output logic returned_loop_clock_o
);
  logic last;
  // Toggle on every rising edge of the returned clock: external divide by two
  always_ff @(posedge clk_i) begin
    last <= rclk_i;
    if (rst_i) begin
      returned_loop_clock_o <= 1'b0;
    end else if (rclk_i && !last) begin
      returned_loop_clock_o <= !returned_loop_clock_o;
    end
  end
endmodule : loop_return_model
`default_nettype wire

// file: pll_clk_consts.svh
// Register offsets, field positions, reset values and loop constants for the clock block
`ifndef PLL_CLK_CONSTS_SVH
`define PLL_CLK_CONSTS_SVH

// ----------------------------------------------------------------
// Register indexes (byte address is four times the index)
// ----------------------------------------------------------------
`define IDX_PIX_PRESCALE 8'h00
`define IDX_PIX_FEEDBACK 8'h01
`define IDX_PIX_POSTSCALE 8'h02
`define IDX_MEM_PRESCALE 8'h03
`define IDX_MEM_FEEDBACK 8'h04
`define IDX_MEM_POSTSCALE 8'h05
`define IDX_LOOP_PRESCALE 8'h06
`define IDX_LOOP_FEEDBACK 8'h07
`define IDX_LOOP_POSTSCALE 8'h08
`define IDX_STATUS 8'h0A
`define IDX_MEMCLK_LOOPCLK_CTRL 8'h39

// ----------------------------------------------------------------
// Fields
// ----------------------------------------------------------------
`define DIV_VALUE_MSB 5
`define EXP_MSB 1
`define Q_SEL_MSB 2
`define MCLK_DOT_BIT 3
`define RCLK_PIXEL_BIT 4
`define CTRL_MSB 4

// ----------------------------------------------------------------
// Divider arithmetic and reset values
// ----------------------------------------------------------------
`define PRESCALE_BASE 7'h41
`define FEEDBACK_MULT 4'h8
`define RST_PRESCALE 8'h80
`define RST_FEEDBACK 8'h00
`define RST_POSTSCALE 8'hF0
`define RST_CTRL 8'h00
`define RST_STEP 16'h0800

`endif

// file: pll_clk_pkg.sv
// Types and shared arithmetic for the clock synthesizer block
package pll_clk_pkg;

  `include "pll_clk_consts.svh"

  // ----------------------------------------------------------------
  // Divider settings of one synthesizer
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] prescale;
    logic [7:0] feedback;
    logic [7:0] postscale;
  } synth_cfg_t;

  typedef enum logic [1:0] {
    PIX_SYNTH,
    MEM_SYNTH,
    LOOP_SYNTH
  } synth_id_t;

  // Prescaler ratio: base minus the six-bit divider value
  function automatic logic [6:0] prescale_ratio(input logic [7:0] reg_value);
    prescale_ratio = `PRESCALE_BASE - {1'b0, reg_value[`DIV_VALUE_MSB:0]};
  endfunction : prescale_ratio

endpackage : pll_clk_pkg

// file: pll_divider_clock_select.sv
// Register file, three synthesizers and output clock selection
//
// Design decision made here: the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
`include "pll_clk_consts.svh"

// Behaviour
// - Loop synthesizer locks to the returned loop clock, aligned with the dot clock.
// - Phase detector compares rising edges after both prescalers.
// - Loop first post-scaler divides by 1, 2, 4 or 8.
// - Loop second post-scaler divides by 2 to 16 in steps of two.
// - Extra loop divide selector sits in bits 2..0 of index 0x39.
// - Divider values use low six bits; exponent uses low two bits.
// - Oscillator runs at eight times reference scaled by feedback over prescale.
// - Pixel and memory synthesizers have only the power-of-two post-scaler.
// - Selector routes loop or pixel output to returned-clock pin.
// - Selector routes memory synthesizer or dot clock to memory clock pin.
module pll_divider_clock_select
  import pll_clk_pkg::*;
#(
  parameter int STEP_W = 16
) (
  // Clock, reset and enable
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [9:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Clock pins
  input wire logic ref_clk_i,
  input wire logic returned_loop_clock_i,
  output logic rclk_o,
  output logic mclk_o,
  output logic dot_clk_o
);

  initial begin
    if (STEP_W < 8 || STEP_W > 24) $error("pll_divider_clock_select: STEP_W out of range");
  end

  synth_cfg_t cfg [3];
  logic [7:0] ctrl;
  logic [2:0] ref_sync;
  logic [2:0] loop_sync;
  logic ref_tick;
  logic loop_tick;
  logic pix_tick;
  logic mem_tick;
  logic lp_tick;
  logic [STEP_W-1:0] pix_step;
  logic [STEP_W-1:0] mem_step;
  logic [STEP_W-1:0] loop_step;
  logic dot_lead;
  logic aligned;
  logic [7:0] idx;
  logic wr_en;
  logic rd_en;
  logic [31:0] next_dat;

  // Pin source changeover: follow, finish the old high phase, wait low for the new source
  typedef enum logic [1:0] {SW_RUN, SW_PARK, SW_WAIT} switch_state_t;

  switch_state_t rclk_state;
  switch_state_t mclk_state;
  logic rclk_from_pix;
  logic mclk_from_dot;
  logic rclk_src_tick;
  logic mclk_src_tick;

  assign idx = adr_i[9:2];
  assign wr_en = cyc_i && stb_i && we_i && sel_i[0] && !ack_o;
  assign rd_en = cyc_i && stb_i && !we_i && !ack_o;

  // ----------------------------------------------------------------
  // Pin synchronisers and rising-edge detection
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ref_sync <= 3'h0;
      loop_sync <= 3'h0;
    end else if (ce_i) begin
      ref_sync <= {ref_sync[1:0], ref_clk_i};
      loop_sync <= {loop_sync[1:0], returned_loop_clock_i};
    end
  end

  assign ref_tick = ref_sync[1] && !ref_sync[2];
  assign loop_tick = loop_sync[1] && !loop_sync[2];

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < 3; i++) begin
        cfg[i] <= '{`RST_PRESCALE, `RST_FEEDBACK, `RST_POSTSCALE};
      end
    end else if (ce_i && wr_en) begin
      case (idx)
        `IDX_PIX_PRESCALE: cfg[PIX_SYNTH].prescale <= dat_i[7:0];
        `IDX_PIX_FEEDBACK: cfg[PIX_SYNTH].feedback <= dat_i[7:0];
        `IDX_PIX_POSTSCALE: cfg[PIX_SYNTH].postscale <= dat_i[7:0];
        `IDX_MEM_PRESCALE: cfg[MEM_SYNTH].prescale <= dat_i[7:0];
        `IDX_MEM_FEEDBACK: cfg[MEM_SYNTH].feedback <= dat_i[7:0];
        `IDX_MEM_POSTSCALE: cfg[MEM_SYNTH].postscale <= dat_i[7:0];
        `IDX_LOOP_PRESCALE: cfg[LOOP_SYNTH].prescale <= dat_i[7:0];
        `IDX_LOOP_FEEDBACK: cfg[LOOP_SYNTH].feedback <= dat_i[7:0];
        `IDX_LOOP_POSTSCALE: cfg[LOOP_SYNTH].postscale <= dat_i[7:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl <= `RST_CTRL;
    end else if (ce_i && wr_en && idx == `IDX_MEMCLK_LOOPCLK_CTRL) begin
      ctrl <= {3'b000, dat_i[`CTRL_MSB:0]};
    end
  end

  // ----------------------------------------------------------------
  // Register reads and acknowledge
  // ----------------------------------------------------------------
  always_comb begin
    next_dat = 32'h0000_0000;
    case (idx)
      `IDX_PIX_PRESCALE: next_dat[7:0] = cfg[PIX_SYNTH].prescale;
      `IDX_PIX_FEEDBACK: next_dat[7:0] = cfg[PIX_SYNTH].feedback;
      `IDX_PIX_POSTSCALE: next_dat[7:0] = cfg[PIX_SYNTH].postscale;
      `IDX_MEM_PRESCALE: next_dat[7:0] = cfg[MEM_SYNTH].prescale;
      `IDX_MEM_FEEDBACK: next_dat[7:0] = cfg[MEM_SYNTH].feedback;
      `IDX_MEM_POSTSCALE: next_dat[7:0] = cfg[MEM_SYNTH].postscale;
      `IDX_LOOP_PRESCALE: next_dat[7:0] = cfg[LOOP_SYNTH].prescale;
      `IDX_LOOP_FEEDBACK: next_dat[7:0] = cfg[LOOP_SYNTH].feedback;
      `IDX_LOOP_POSTSCALE: next_dat[7:0] = cfg[LOOP_SYNTH].postscale;
      `IDX_MEMCLK_LOOPCLK_CTRL: next_dat[7:0] = ctrl;
      `IDX_STATUS: next_dat = {8'h00, loop_step[STEP_W-1 -: 8], 13'h0000, aligned, mclk_o, rclk_o};
      default: next_dat = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else if (ce_i) begin
      ack_o <= cyc_i && stb_i && !ack_o;
      dat_o <= rd_en ? next_dat : 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // Synthesizers
  // ----------------------------------------------------------------
  pll_synth #(.HAS_Q(1'b0), .STEP_W(STEP_W)) u_pix (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .ref_tick_i(ref_tick),
    .cfg_i(cfg[PIX_SYNTH]),
    .q_sel_i(3'h0),
    .out_tick_o(pix_tick),
    .step_o(pix_step)
  );

  pll_synth #(.HAS_Q(1'b0), .STEP_W(STEP_W)) u_mem (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .ref_tick_i(ref_tick),
    .cfg_i(cfg[MEM_SYNTH]),
    .q_sel_i(3'h0),
    .out_tick_o(mem_tick),
    .step_o(mem_step)
  );

  // Loop synthesizer references the clock returned by the controller
  pll_synth #(.HAS_Q(1'b1), .STEP_W(STEP_W)) u_loop (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .ref_tick_i(loop_tick),
    .cfg_i(cfg[LOOP_SYNTH]),
    .q_sel_i(ctrl[`Q_SEL_MSB:0]),
    .out_tick_o(lp_tick),
    .step_o(loop_step)
  );

  // ----------------------------------------------------------------
  // Alignment of the returned clock with the dot clock
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dot_lead <= 1'b0;
      aligned <= 1'b0;
    end else if (ce_i) begin
      if (pix_tick && !loop_tick) begin
        dot_lead <= 1'b1;
      end else if (loop_tick) begin
        dot_lead <= 1'b0;
      end
      if (loop_tick) begin
        aligned <= pix_tick || dot_lead;
      end
    end
  end

  // ----------------------------------------------------------------
  // Source changeover for the returned-clock and memory clock pins
  // ----------------------------------------------------------------
  // A pin changes source only while low and with no tick pending, then stays
  // low until the new source ticks once; no phase is shorter than half a
  // period of either source. A new source that never ticks leaves the pin low; an old one that stops while high leaves it high.
  assign rclk_src_tick = rclk_from_pix ? pix_tick : lp_tick;
  assign mclk_src_tick = mclk_from_dot ? pix_tick : mem_tick;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rclk_state <= SW_RUN;
      rclk_from_pix <= 1'b0;
    end else if (ce_i) begin
      case (rclk_state)
        SW_RUN: begin
          if (ctrl[`RCLK_PIXEL_BIT] != rclk_from_pix) begin
            rclk_state <= SW_PARK;
          end
        end
        SW_PARK: begin
          if (!rclk_o && !rclk_src_tick) begin
            rclk_from_pix <= ctrl[`RCLK_PIXEL_BIT];
            rclk_state <= SW_WAIT;
          end
        end
        SW_WAIT: begin
          if (rclk_src_tick) begin
            rclk_state <= SW_RUN;
          end
        end
        default: rclk_state <= SW_RUN;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mclk_state <= SW_RUN;
      mclk_from_dot <= 1'b0;
    end else if (ce_i) begin
      case (mclk_state)
        SW_RUN: begin
          if (ctrl[`MCLK_DOT_BIT] != mclk_from_dot) begin
            mclk_state <= SW_PARK;
          end
        end
        SW_PARK: begin
          if (!mclk_o && !mclk_src_tick) begin
            mclk_from_dot <= ctrl[`MCLK_DOT_BIT];
            mclk_state <= SW_WAIT;
          end
        end
        SW_WAIT: begin
          if (mclk_src_tick) begin
            mclk_state <= SW_RUN;
          end
        end
        default: mclk_state <= SW_RUN;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Output clocks; each toggles only on its selected source edge
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dot_clk_o <= 1'b0;
    end else if (ce_i && pix_tick) begin
      dot_clk_o <= !dot_clk_o;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rclk_o <= 1'b0;
    end else if (ce_i && rclk_state != SW_WAIT && rclk_src_tick) begin
      rclk_o <= !rclk_o;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mclk_o <= 1'b0;
    end else if (ce_i && mclk_state != SW_WAIT && mclk_src_tick) begin
      mclk_o <= !mclk_o;
    end
  end

endmodule : pll_divider_clock_select

`default_nettype wire

// file: pll_divider_clock_select_props.sv
// Bus and clock pin checks for the clock block
`timescale 1ns/1ps
`default_nettype none
module pll_divider_clock_select_props (
  // Watched ports
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [9:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  input wire logic rclk_o,
  input wire logic mclk_o,
  input wire logic dot_clk_o
);
  // ----------------------------------------------------------------
  // Shadow of the control register
  // ----------------------------------------------------------------
  logic take;
  logic rd;
  logic [7:0] idx;
  logic [4:0] ctrl;
  assign take = cyc_i && stb_i && !ack_o && ce_i;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl <= 5'h00;
    end else if (take && we_i && sel_i[0] && adr_i[9:2] == 8'h39) begin
      ctrl <= dat_i[4:0];
    end
  end
  always_ff @(posedge clk_i) begin
    if (take) begin
      idx <= adr_i[9:2];
      rd <= !we_i;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_ack_pulse; ack_o && ce_i |=> !ack_o; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  property p_ack_answer; take |=> ack_o; endproperty
  a_ack_answer: assert property (p_ack_answer) else $error("request not answered");
  property p_ack_cause; ack_o |-> $past(take) || $past(ack_o && !ce_i); endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  property p_dat_idle; !ack_o |-> dat_o == 32'h0; endproperty
  a_dat_idle: assert property (p_dat_idle) else $error("read data outside ack");
  property p_dat_upper; ack_o && !(rd && idx == 8'h0A) |-> dat_o[31:8] == 24'h0; endproperty
  a_dat_upper: assert property (p_dat_upper) else $error("upper read bits set");
  property p_ctrl_read; ack_o && rd && idx == 8'h39 |-> dat_o[7:0] == {3'h0, ctrl}; endproperty
  a_ctrl_read: assert property (p_ctrl_read) else $error("control readback");
  property p_unmapped;
    ack_o && rd && idx != 8'h39 && (idx == 8'h09 || idx > 8'h0A) |-> dat_o == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_freeze;
    !ce_i |=> $stable({rclk_o, mclk_o, dot_clk_o, ack_o});
  endproperty
  a_freeze: assert property (p_freeze) else $error("outputs moved while frozen");
  property p_reset; $fell(rst_i) |-> !ack_o && !rclk_o && !mclk_o && !dot_clk_o; endproperty
  a_reset: assert property (p_reset) else $error("outputs not cleared by reset");
endmodule : pll_divider_clock_select_props
bind pll_divider_clock_select pll_divider_clock_select_props i_pll_divider_clock_select_props (
  .clk_i, .rst_i, .ce_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o,
  .rclk_o, .mclk_o, .dot_clk_o);
`default_nettype wire

// file: pll_synth.sv
// One clock synthesizer: prescalers, phase detector, oscillator and post-scalers
`timescale 1ns/1ps
`default_nettype none
`include "pll_clk_consts.svh"

module pll_synth
  import pll_clk_pkg::*;
#(
  parameter bit HAS_Q = 1'b0,
  parameter int STEP_W = 16
) (
  // Clock and control
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Reference and settings
  input wire logic ref_tick_i,
  input wire synth_cfg_t cfg_i,
  input wire logic [2:0] q_sel_i,
  // Results
  output logic out_tick_o,
  output logic [STEP_W-1:0] step_o
);

  initial begin
    if (STEP_W < 8) $error("pll_synth: STEP_W below 8");
  end

  logic ref_div_tick;
  logic fb_div_tick;
  logic osc_tick;
  logic post_tick;
  logic q_tick;
  logic [STEP_W-1:0] phase;
  logic [STEP_W:0] next_phase;
  logic [9:0] fb_ratio;
  logic [3:0] post_ratio;
  logic [4:0] q_ratio;

  assign fb_ratio = `FEEDBACK_MULT * {3'b000, prescale_ratio(cfg_i.feedback)};
  assign post_ratio = 4'(1) << cfg_i.postscale[`EXP_MSB:0];
  assign q_ratio = {1'b0, q_sel_i, 1'b0} + 5'h02;
  assign next_phase = {1'b0, phase} + {1'b0, step_o};

  // ----------------------------------------------------------------
  // Prescalers ahead of the phase detector
  // ----------------------------------------------------------------
  edge_divider #(.W(10)) u_ref_pre (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .tick_i(ref_tick_i),
    .ratio_i({3'b000, prescale_ratio(cfg_i.prescale)}),
    .tick_o(ref_div_tick)
  );

  edge_divider #(.W(10)) u_fb_pre (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .tick_i(osc_tick),
    .ratio_i(fb_ratio),
    .tick_o(fb_div_tick)
  );

  // ----------------------------------------------------------------
  // Phase detector steering the oscillator step
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      step_o <= STEP_W'(`RST_STEP);
    end else if (ce_i && (ref_div_tick != fb_div_tick)) begin
      if (ref_div_tick && step_o != '1) begin
        step_o <= step_o + STEP_W'(1);
      end else if (fb_div_tick && step_o > STEP_W'(1)) begin
        step_o <= step_o - STEP_W'(1);
      end
    end
  end

  // ----------------------------------------------------------------
  // Oscillator: phase accumulator, carry is one oscillator edge
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      phase <= '0;
      osc_tick <= 1'b0;
    end else if (ce_i) begin
      phase <= next_phase[STEP_W-1:0];
      osc_tick <= next_phase[STEP_W];
    end
  end

  // ----------------------------------------------------------------
  // Post-scalers
  // ----------------------------------------------------------------
  edge_divider #(.W(4)) u_post (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .tick_i(osc_tick),
    .ratio_i(post_ratio),
    .tick_o(post_tick)
  );

  edge_divider #(.W(5)) u_q (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .tick_i(post_tick),
    .ratio_i(q_ratio),
    .tick_o(q_tick)
  );

  assign out_tick_o = HAS_Q ? q_tick : post_tick;

endmodule : pll_synth

`default_nettype wire

// file: test_pll_divider_clock_select.sv
// Testbench for the clock synthesizer block
`timescale 1ns/1ps
`default_nettype none
module test_pll_divider_clock_select;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic ce_i = 1'b1;
  logic cyc_i = 1'b0;
  logic stb_i = 1'b0;
  logic we_i = 1'b0;
  logic [9:0] adr_i = 10'h000;
  logic [3:0] sel_i = 4'hF;
  logic [31:0] dat_i = 32'h0;
  logic [31:0] dat_o;
  logic ack_o;
  logic ref_clk_i = 1'b0;
  logic returned_loop_clock_i;
  logic rclk_o;
  logic mclk_o;
  logic dot_clk_o;
  int mismatches = 0;
  int compares = 0;
  int d;
  int r;
  int m;
  always #20 clk_i = !clk_i;
  // Reference period of 256 system cycles
  always #5120 ref_clk_i = !ref_clk_i;
  pll_divider_clock_select i_pll_divider_clock_select (.clk_i(clk_i), .rst_i(rst_i),
    .ce_i(ce_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
    .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .ref_clk_i(ref_clk_i),
    .returned_loop_clock_i(returned_loop_clock_i), .rclk_o(rclk_o), .mclk_o(mclk_o),
    .dot_clk_o(dot_clk_o));
  loop_return_model i_loop_return_model (.clk_i(clk_i), .rst_i(rst_i), .rclk_i(rclk_o),
    .returned_loop_clock_o(returned_loop_clock_i));
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic stop_test();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : stop_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      $display("wrong value at %0t got %h expected %h", $time, got, exp);
      mismatches++;
    end
  endtask : chk
  task automatic near(input int got, input int exp);
    compares++;
    if (got < exp - exp / 8 - 2 || got > exp + exp / 8 + 2) begin
      $display("wrong value at %0t got %h expected %h", $time, got, exp);
      mismatches++;
    end
  endtask : near
  task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] v,
    input logic [3:0] s, output logic [31:0] q);
    int n;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    sel_i <= s;
    adr_i <= {idx, 2'h0};
    dat_i <= {24'h0, v};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    if (n >= 20) begin
      mismatches++;
      stop_test();
    end
  endtask : wb
  task automatic wr(input logic [7:0] idx, input logic [7:0] v);
    logic [31:0] q;
    wb(1'b1, idx, v, 4'hF, q);
  endtask : wr
  task automatic rd(input logic [7:0] idx, input logic [31:0] exp);
    logic [31:0] q;
    wb(1'b0, idx, 8'h00, 4'hF, q);
    chk(q, exp);
  endtask : rd
  task automatic count();
    logic pd;
    logic pr;
    logic pm;
    repeat (512) @(posedge clk_i);
    d = 0;
    r = 0;
    m = 0;
    repeat (4096) begin
      pd = dot_clk_o;
      pr = rclk_o;
      pm = mclk_o;
      @(negedge clk_i);
      d += int'(dot_clk_o !== pd);
      r += int'(rclk_o !== pr);
      m += int'(mclk_o !== pm);
    end
  endtask : count
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regs();
    logic [31:0] q;
    for (int s = 0; s < 3; s++) begin
      rd(8'(3 * s), 32'h80);
      rd(8'(3 * s + 1), 32'h00);
      rd(8'(3 * s + 2), 32'hF0);
    end
    wr(8'h06, 8'hB1);
    wr(8'h08, 8'hF1);
    rd(8'h06, 32'hB1);
    rd(8'h08, 32'hF1);
    for (int k = 0; k < 8; k++) begin
      wr(8'h39, 8'(k));
      rd(8'h39, 32'(k));
    end
    wr(8'h39, 8'hFF);
    rd(8'h39, 32'h1F);
    wb(1'b1, 8'h39, 8'h00, 4'hE, q);
    rd(8'h39, 32'h1F);
    rd(8'h20, 32'h00);
    wr(8'h39, 8'h00);
  endtask : t_regs
  task automatic t_clocks();
    logic [31:0] q;
    for (int p = 0; p < 4; p++) begin
      wr(8'h02, 8'(8'hF0 + p));
      count();
      near(d, 128 >> p);
    end
    wr(8'h02, 8'hF0);
    wr(8'h00, 8'hA8);
    wr(8'h01, 8'hE8);
    wr(8'h03, 8'hA8);
    wr(8'h04, 8'hE8);
    wr(8'h05, 8'hF3);
    count();
    near(d, 128);
    near(m, 16);
    wr(8'h39, 8'h18);
    count();
    near(m, 128);
    near(r, 128);
    wb(1'b0, 8'h0A, 8'h00, 4'hF, q);
    chk(32'(q[2]), 32'h1);
    wr(8'h39, 8'h00);
  endtask : t_clocks
  task automatic t_freeze();
    logic pd;
    @(posedge clk_i);
    ce_i <= 1'b0;
    @(posedge clk_i);
    pd = dot_clk_o;
    repeat (40) @(posedge clk_i);
    chk({31'h0, dot_clk_o}, {31'h0, pd});
    ce_i <= 1'b1;
    rd(8'h08, 32'hF1);
  endtask : t_freeze
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_clocks();
    t_freeze();
    stop_test();
  end
endmodule : test_pll_divider_clock_select
`default_nettype wire
